// File: msd_decoder.sv
/*
 * msd_decoder: decodes the compute field of a core instruction for
 * multiplier, shifter and accumulator-move operations; control and
 * counters sit behind an Avalon-MM slave with waitrequest.
 * Assumes the sequencer drives one field per i_instr_valid cycle,
 * synchronous to i_mclk, and that the units take every decode.
 */
`timescale 1ns/1ps
`default_nettype none
module msd_decoder #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst,
  input  wire logic [3:0]            i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic      [31:0]           o_avs_readdata,
  output logic                       o_avs_waitrequest,
  input  wire logic                  i_instr_valid,
  input  wire logic                  i_type6,
  input  wire logic [22:0]           i_compute,
  output logic                       o_dec_valid,
  output logic                       o_illegal,
  output msd_pkg::msd_unit_t         o_unit,
  output msd_pkg::msd_mul_op_t       o_mul_op,
  output msd_pkg::msd_shf_op_t       o_shf_op,
  output logic                       o_y_signed,
  output logic                       o_x_signed,
  output logic                       o_fractional,
  output logic                       o_round,
  output logic                       o_to_rf,
  output logic                       o_acc_sel,
  output logic                       o_shf_imm,
  output logic [7:0]                 o_imm_data,
  output logic                       o_or_merge,
  output logic                       o_sign_extend_option,
  output logic                       o_no_pointer_update,
  output logic                       o_lsc_extended,
  output logic                       o_move_to_acc,
  output logic [1:0]                 o_seg_index,
  output logic [3:0]                 o_rn,
  output logic [3:0]                 o_rx,
  output logic [3:0]                 o_ry,
  output logic [5:0]                 o_fld_msb,
  output logic [5:0]                 o_fld_lsb
);
  import msd_pkg::*;

  msd_bus_state_t   bus_state_ff;
  msd_bus_state_t   nxt_bus_state;
  logic [1:0]       ctrl_ff;
  logic [CNT_W-1:0] dec_cnt_ff;
  logic [CNT_W-1:0] ill_cnt_ff;
  logic [31:0]      nxt_rdata;
  logic             bus_req;
  logic             take;

  logic [7:0]       opc;
  logic [2:0]       cu;
  msd_unit_t        nxt_unit;
  msd_mul_op_t      nxt_mul_op;
  msd_shf_op_t      nxt_shf_op;
  logic             nxt_ill;
  logic             nxt_y_signed;
  logic             nxt_x_signed;
  logic             nxt_frac;
  logic             nxt_round;
  logic             nxt_to_rf;
  logic             nxt_acc_sel;
  logic             nxt_or;
  logic             nxt_sext;
  logic             nxt_nu;
  logic             nxt_lsc_ext;
  logic             nxt_move_acc;
  logic [1:0]       nxt_seg;
  logic [3:0]       nxt_rn;
  logic [3:0]       nxt_rx;
  logic [3:0]       nxt_ry;

  // Destination code: high bit low means register file, low bit secondary
  function automatic logic [1:0] dest_decode(input logic [1:0] d);
    dest_decode = {~d[1], d[0]};
  endfunction

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + {{(CNT_W-1){1'b0}}, 1'b1};
  endfunction

  // Bus slave: one wait cycle, then a single acknowledge cycle
  assign bus_req = i_avs_read | i_avs_write;

  always_comb begin
    nxt_bus_state = BUS_IDLE;
    case (bus_state_ff)
      BUS_IDLE: nxt_bus_state = bus_req ? BUS_ACK : BUS_IDLE;
      BUS_ACK:  nxt_bus_state = BUS_IDLE;
      default:  nxt_bus_state = BUS_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bus_state_ff      <= BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
    end else begin
      bus_state_ff      <= nxt_bus_state;
      o_avs_waitrequest <= (nxt_bus_state != BUS_ACK);
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (i_avs_address == REG_CTRL) begin
      nxt_rdata[1:0] = ctrl_ff;
    end else if (i_avs_address == REG_STATUS) begin
      nxt_rdata[0]   = o_illegal;
      nxt_rdata[2:1] = o_unit;
      nxt_rdata[5:3] = o_mul_op;
      nxt_rdata[10:6] = o_shf_op;
    end else if (i_avs_address == REG_DEC_COUNT) begin
      nxt_rdata[CNT_W-1:0] = dec_cnt_ff;
    end else if (i_avs_address == REG_ILL_COUNT) begin
      nxt_rdata[CNT_W-1:0] = ill_cnt_ff;
    end
  end

  // Data captured on entry to the acknowledge cycle and held through it
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (bus_state_ff == BUS_IDLE && i_avs_read) begin
      o_avs_readdata <= nxt_rdata;
    end
  end

  // Write lands only at the edge where waitrequest is seen low
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ctrl_ff <= CTRL_RESET;
    end else if (bus_state_ff == BUS_ACK && i_avs_write &&
                 i_avs_address == REG_CTRL && i_avs_byteenable[0]) begin
      ctrl_ff <= i_avs_writedata[1:0];
    end
  end

  // Decoder
  assign take = i_instr_valid & ctrl_ff[CTRL_DEC_EN_BIT];
  assign cu   = i_compute[CU_MSB:CU_LSB];
  // Immediate forms carry only six opcode bits; low two read as zero
  assign opc  = i_type6 ? {i_compute[IMM_OPC_MSB:IMM_OPC_LSB], 2'b00}
                        : i_compute[OPC_MSB:OPC_LSB];

  always_comb begin
    nxt_unit     = UNIT_NONE;
    nxt_mul_op   = MUL_NONE;
    nxt_shf_op   = SHF_NONE;
    nxt_ill      = 1'b0;
    nxt_y_signed = 1'b0;
    nxt_x_signed = 1'b0;
    nxt_frac     = 1'b0;
    nxt_round    = 1'b0;
    nxt_to_rf    = 1'b1;
    nxt_acc_sel  = 1'b0;
    nxt_or       = 1'b0;
    nxt_sext     = 1'b0;
    nxt_nu       = 1'b0;
    nxt_lsc_ext  = 1'b0;
    nxt_move_acc = 1'b0;
    nxt_seg      = 2'h0;
    nxt_rn       = i_compute[RN_LSB +: 4];
    nxt_rx       = i_compute[RX_LSB +: 4];
    nxt_ry       = i_compute[RY_LSB +: 4];
    if (i_type6) begin
      nxt_unit = UNIT_SHF;
      nxt_rn   = i_compute[IMM_RN_LSB +: 4];
      nxt_rx   = i_compute[IMM_RX_LSB +: 4];
      nxt_ry   = 4'h0;
      nxt_ill  = i_compute[IMM_FMT_BIT];
    end else if (cu == CU_MUL) begin
      nxt_unit = UNIT_MUL;
      {nxt_to_rf, nxt_acc_sel} = dest_decode(opc[DEST_LSB +: 2]);
      case (opc[7:6])
        GRP_PRODUCT, GRP_ACC_ADD, GRP_ACC_SUB: begin
          nxt_y_signed = opc[MOD_Y_BIT];
          nxt_x_signed = opc[MOD_X_BIT];
          nxt_frac     = opc[MOD_F_BIT];
          nxt_round    = opc[MOD_R_BIT];
          if (opc[7:6] == GRP_PRODUCT) begin
            nxt_mul_op = MUL_PRODUCT;
            // A plain product reads no accumulator into the registers
            nxt_ill    = (opc[DEST_LSB +: 2] == 2'h1);
          end else if (opc[7:6] == GRP_ACC_ADD) begin
            nxt_mul_op = MUL_ACC_ADD;
          end else begin
            nxt_mul_op = MUL_ACC_SUB;
          end
        end
        default: begin
          if (opc[7:4] == HI_CLAMP) begin
            nxt_mul_op   = MUL_CLAMP_TO_RANGE;
            nxt_frac     = opc[MOD_F_BIT];
            nxt_y_signed = opc[MOD_R_BIT];
            nxt_x_signed = opc[MOD_R_BIT];
          end else if (opc[7:4] == HI_ROUND && opc[MOD_F_BIT]) begin
            nxt_mul_op   = MUL_ROUND_ACCUMULATOR;
            nxt_frac     = 1'b1;
            nxt_round    = 1'b1;
            nxt_y_signed = opc[MOD_R_BIT];
            nxt_x_signed = opc[MOD_R_BIT];
          end else if (opc == OPC_CLR_PRI || opc == OPC_CLR_SEC) begin
            nxt_mul_op = MUL_CLEAR;
          end else if (opc == OPC_FLOAT_MUL) begin
            nxt_mul_op = MUL_FLOAT;
            nxt_to_rf  = 1'b1;
          end else begin
            nxt_ill = 1'b1;
          end
        end
      endcase
    end else if (cu == CU_MOVE) begin
      nxt_unit     = UNIT_MOVE;
      nxt_move_acc = i_compute[MOVE_DIR_BIT];
      nxt_to_rf    = ~i_compute[MOVE_DIR_BIT];
      nxt_rn       = i_compute[MOVE_DREG_LSB +: 4];
      nxt_acc_sel  = i_compute[MOVE_SEG_LSB + SEG_BANK_BIT];
      nxt_seg      = i_compute[MOVE_SEG_LSB +: 2];
      // Segment 3 and codes with bit 3 set name no segment
      nxt_ill      = (i_compute[MOVE_SEG_LSB +: 2] == 2'h3) ||
                     i_compute[MOVE_SEG_LSB + 3] ||
                     (i_compute[MOVE_ZERO_MSB:MOVE_ZERO_LSB] != 3'h0);
    end else if (cu == CU_SHF) begin
      nxt_unit = UNIT_SHF;
    end else begin
      nxt_ill = 1'b1;
    end
    if (nxt_unit == UNIT_SHF) begin
      case (opc)
        8'h00: nxt_shf_op = SHF_LOGICAL;
        8'h20: begin
          nxt_shf_op = SHF_LOGICAL;
          nxt_or     = 1'b1;
        end
        8'h04: nxt_shf_op = SHF_ARITHMETIC;
        8'h24: begin
          nxt_shf_op = SHF_ARITHMETIC;
          nxt_or     = 1'b1;
        end
        8'h08: nxt_shf_op = SHF_CIRCULAR;
        8'hC0: nxt_shf_op = SHF_BIT_SET;
        8'hC4: nxt_shf_op = SHF_BIT_CLEAR;
        8'hC8: nxt_shf_op = SHF_BIT_TOGGLE;
        8'hCC: nxt_shf_op = SHF_BIT_TEST;
        8'h44, 8'h4C, 8'h64, 8'h6C: begin
          nxt_shf_op = SHF_FIELD_DEPOSIT;
          nxt_sext   = opc[3];
          nxt_or     = opc[5];
        end
        8'h40, 8'h48: begin
          nxt_shf_op = SHF_FIELD_EXTRACT;
          nxt_sext   = opc[3];
        end
        8'h80, 8'h84: begin
          nxt_shf_op  = SHF_LEADING_SIGN;
          nxt_lsc_ext = opc[2];
        end
        8'h88: nxt_shf_op = SHF_LEADING_ZERO;
        8'h8C: nxt_shf_op = SHF_LEADING_ONE;
        8'h90: nxt_shf_op = SHF_PACK;
        8'h94: nxt_shf_op = SHF_WIDEN;
        8'h74: nxt_shf_op = SHF_STREAM_DEPOSIT;
        8'h50, 8'h58: begin
          nxt_shf_op = SHF_STREAM_EXTRACT;
          nxt_nu     = opc[3];
        end
        8'h7C: nxt_shf_op = SHF_FIFO_PTR_WRITE;
        8'h70: nxt_shf_op = SHF_FIFO_PTR_READ;
        default: nxt_ill = 1'b1;
      endcase
      // Earlier variants lack the stream ops; control bit stands in for that
      if ((nxt_shf_op == SHF_STREAM_DEPOSIT || nxt_shf_op == SHF_STREAM_EXTRACT ||
           nxt_shf_op == SHF_FIFO_PTR_WRITE || nxt_shf_op == SHF_FIFO_PTR_READ) &&
          !ctrl_ff[CTRL_STREAM_BIT]) begin
        nxt_ill = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_dec_valid <= 1'b0;
    end else begin
      o_dec_valid <= take;
    end
  end

  // Decode outputs hold their last value between valid cycles
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_illegal            <= 1'b0;
      o_unit               <= UNIT_NONE;
      o_mul_op             <= MUL_NONE;
      o_shf_op             <= SHF_NONE;
      o_y_signed           <= 1'b0;
      o_x_signed           <= 1'b0;
      o_fractional         <= 1'b0;
      o_round              <= 1'b0;
      o_to_rf              <= 1'b0;
      o_acc_sel            <= 1'b0;
      o_shf_imm            <= 1'b0;
      o_imm_data           <= 8'h00;
      o_or_merge           <= 1'b0;
      o_sign_extend_option <= 1'b0;
      o_no_pointer_update  <= 1'b0;
      o_lsc_extended       <= 1'b0;
      o_move_to_acc        <= 1'b0;
      o_seg_index          <= 2'h0;
      o_rn                 <= 4'h0;
      o_rx                 <= 4'h0;
      o_ry                 <= 4'h0;
    end else if (take) begin
      o_illegal            <= nxt_ill;
      o_unit               <= nxt_unit;
      o_mul_op             <= nxt_mul_op;
      o_shf_op             <= nxt_shf_op;
      o_y_signed           <= nxt_y_signed;
      o_x_signed           <= nxt_x_signed;
      o_fractional         <= nxt_frac;
      o_round              <= nxt_round;
      o_to_rf              <= nxt_to_rf;
      o_acc_sel            <= nxt_acc_sel;
      o_shf_imm            <= i_type6;
      o_imm_data           <= i_type6 ? i_compute[IMM_DATA_LSB +: 8] : 8'h00;
      o_or_merge           <= nxt_or;
      o_sign_extend_option <= nxt_sext;
      o_no_pointer_update  <= nxt_nu;
      o_lsc_extended       <= nxt_lsc_ext;
      o_move_to_acc        <= nxt_move_acc;
      o_seg_index          <= nxt_seg;
      o_rn                 <= nxt_rn;
      o_rx                 <= nxt_rx;
      o_ry                 <= nxt_ry;
    end
  end

  // Constant, but registered so every output leaves a flop
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_fld_msb <= SHF_FLD_MSB;
      o_fld_lsb <= SHF_FLD_LSB;
    end
  end

  // Counters stick at full scale rather than wrap
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      dec_cnt_ff <= '0;
      ill_cnt_ff <= '0;
    end else if (take) begin
      dec_cnt_ff <= sat_inc(dec_cnt_ff);
      if (nxt_ill) begin
        ill_cnt_ff <= sat_inc(ill_cnt_ff);
      end
    end
  end
endmodule // msd_decoder
`default_nettype wire

// File: msd_decoder_bench.sv
/* msd_decoder_bench: self-checking bench for msd_decoder.
   Assumes msd_pkg, the sequencer model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module msd_decoder_bench;
  import msd_pkg::*;
  logic mclk, rst, rd, wr, req, req_t6, iv, t6, waitreq, dv, ill, ys, xs, frac, rnd, to_rf, accs, simm;
  logic orm, sxt, npu, lext, mta;
  logic [3:0] adr, rn, rx, ry;
  logic [31:0] wdat, rdata;
  logic [22:0] req_f, cmp, f;
  logic [7:0] imm;
  logic [1:0] seg;
  logic [5:0] fmsb, flsb;
  msd_unit_t unit;
  msd_mul_op_t mop;
  msd_shf_op_t sop;
  int fail_count, comparisons, nill, ndec, cyc;
  localparam logic [7:0] SOPC [26] = '{8'h00, 8'h20, 8'h04, 8'h24, 8'h08, 8'hC0, 8'hC4, 8'hC8, 8'hCC, 8'h44,
    8'h4C, 8'h64, 8'h6C, 8'h40, 8'h48, 8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'h74, 8'h50, 8'h58, 8'h7C, 8'h70};
  localparam msd_shf_op_t SOPS [26] = '{SHF_LOGICAL, SHF_LOGICAL, SHF_ARITHMETIC, SHF_ARITHMETIC, SHF_CIRCULAR,
    SHF_BIT_SET, SHF_BIT_CLEAR, SHF_BIT_TOGGLE, SHF_BIT_TEST, SHF_FIELD_DEPOSIT, SHF_FIELD_DEPOSIT,
    SHF_FIELD_DEPOSIT, SHF_FIELD_DEPOSIT, SHF_FIELD_EXTRACT, SHF_FIELD_EXTRACT, SHF_LEADING_SIGN, SHF_LEADING_SIGN,
    SHF_LEADING_ZERO, SHF_LEADING_ONE, SHF_PACK, SHF_WIDEN, SHF_STREAM_DEPOSIT, SHF_STREAM_EXTRACT,
    SHF_STREAM_EXTRACT, SHF_FIFO_PTR_WRITE, SHF_FIFO_PTR_READ};
  // Flags: or-merge, sign extend, no pointer update, extended
  localparam logic [3:0] SFLG [26] = '{4'h0, 4'h8, 4'h0, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h8,
    4'hC, 4'h0, 4'h4, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h0, 4'h0};
  localparam logic [3:0] SEGS [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};

  always #12.5 mclk = ~mclk;

  msd_seq_model u_seq (.i_mclk(mclk), .i_rst(rst), .i_req(req), .i_req_type6(req_t6), .i_req_field(req_f),
    .o_instr_valid(iv), .o_type6(t6), .o_compute(cmp));
  msd_decoder uut (.i_mclk(mclk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdat), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_instr_valid(iv), .i_type6(t6), .i_compute(cmp), .o_dec_valid(dv), .o_illegal(ill), .o_unit(unit),
    .o_mul_op(mop), .o_shf_op(sop), .o_y_signed(ys), .o_x_signed(xs), .o_fractional(frac), .o_round(rnd),
    .o_to_rf(to_rf), .o_acc_sel(accs), .o_shf_imm(simm), .o_imm_data(imm), .o_or_merge(orm),
    .o_sign_extend_option(sxt), .o_no_pointer_update(npu), .o_lsc_extended(lext), .o_move_to_acc(mta),
    .o_seg_index(seg), .o_rn(rn), .o_rx(rx), .o_ry(ry), .o_fld_msb(fmsb), .o_fld_lsb(flsb));

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Bus tasks are entered just after a rising edge
  task automatic bw(input logic [3:0] a, input logic [31:0] d);
    adr <= a; wdat <= d; wr <= 1'b1;
    do @(posedge mclk); while (waitreq !== 1'b0);
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic br(input logic [3:0] a, input logic [31:0] e);
    adr <= a; rd <= 1'b1;
    do @(posedge mclk); while (waitreq !== 1'b0);
    check(rdata, e);
    rd <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic dec(input logic t, input logic [22:0] fl, input logic ev, input logic il,
                     input msd_unit_t u, input msd_mul_op_t mo, input msd_shf_op_t so);
    req <= 1'b1; req_t6 <= t; req_f <= fl;
    @(posedge mclk);
    req <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      #1;
      if (dv === 1'b1) break;
    end
    check(dv, ev);
    if (ev && il) nill++;
    if (ev) ndec++;
    if (ev) check(ill, il);
    if (ev && !il) check({unit, mop, sop}, {u, mo, so});
    @(posedge mclk);
  endtask

  function automatic logic [22:0] mf(input logic [7:0] o);
    return {CU_MUL, o, 12'h321};
  endfunction

  // Flags are y, x, format, round, to register file, accumulator select
  task automatic tm(input logic [7:0] o, input msd_mul_op_t op, input logic [5:0] fl);
    dec(1'b0, mf(o), 1'b1, 1'b0, UNIT_MUL, op, SHF_NONE);
    check(to_rf, fl[1]);
    if (op != MUL_FLOAT) check(accs, fl[0]);
    if (op inside {MUL_PRODUCT, MUL_ACC_ADD, MUL_ACC_SUB, MUL_ROUND_ACCUMULATOR}) check({ys, xs, frac, rnd}, fl[5:2]);
    if (op == MUL_CLAMP_TO_RANGE) check({ys, xs, frac}, fl[5:3]);
  endtask

  task automatic t_mul;
    tm(8'h69, MUL_PRODUCT, 6'b101110);
    tm(8'h74, MUL_PRODUCT, 6'b110000);
    tm(8'h70, MUL_PRODUCT, 6'b110010);
    tm(8'h48, MUL_PRODUCT, 6'b001010);
    tm(8'h79, MUL_PRODUCT, 6'b111110);
    tm(8'h9C, MUL_ACC_ADD, 6'b011000);
    tm(8'hB6, MUL_ACC_ADD, 6'b110001);
    tm(8'hA3, MUL_ACC_ADD, 6'b100111);
    tm(8'hE3, MUL_ACC_SUB, 6'b100111);
    tm(8'hD4, MUL_ACC_SUB, 6'b010000);
    tm(8'h09, MUL_CLAMP_TO_RANGE, 6'b111010);
    tm(8'h07, MUL_CLAMP_TO_RANGE, 6'b110001);
    tm(8'h02, MUL_CLAMP_TO_RANGE, 6'b000011);
    tm(8'h19, MUL_ROUND_ACCUMULATOR, 6'b111110);
    tm(8'h1E, MUL_ROUND_ACCUMULATOR, 6'b001101);
    tm(8'h30, MUL_FLOAT, 6'b000010);
    tm(8'h16, MUL_CLEAR, 6'b000001);
    dec(1'b0, mf(8'h11), 1'b1, 1'b1, UNIT_MUL, MUL_NONE, SHF_NONE);
    $display("test mul done");
  endtask

  task automatic t_shf;
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 26; i++) begin
        f = m ? {1'b0, SOPC[i][7:2], 8'hA5, 4'h6, 4'h9} : {CU_SHF, SOPC[i], 4'h6, 4'h9, 4'h3};
        dec(m[0], f, 1'b1, 1'b0, UNIT_SHF, MUL_NONE, SOPS[i]);
        check({orm, sxt, npu, lext}, SFLG[i]);
        check({simm, imm, rn, rx, ry}, {m[0], m ? 8'hA5 : 8'h00, 4'h6, 4'h9, m ? 4'h0 : 4'h3});
      end
    end
    dec(1'b0, {CU_SHF, 8'h01, 12'h0}, 1'b1, 1'b1, UNIT_SHF, MUL_NONE, SHF_NONE);
    dec(1'b1, {1'b1, 6'h01, 16'h0}, 1'b1, 1'b1, UNIT_SHF, MUL_NONE, SHF_NONE);
    $display("test shifter done");
  endtask

  task automatic t_move;
    dec(1'b0, {CU_MOVE, 4'h0, 4'h3, 12'hA00}, 1'b1, 1'b1, UNIT_MOVE, MUL_NONE, SHF_NONE);
    for (int d = 0; d < 2; d++) begin
      for (int i = 0; i < 6; i++) begin
        dec(1'b0, {CU_MOVE, 3'h0, d[0], SEGS[i], 12'hA00}, 1'b1, 1'b0, UNIT_MOVE, MUL_NONE, SHF_NONE);
        check({mta, accs, seg, rn}, {d[0], SEGS[i][2:0], 4'hA});
      end
    end
    br(REG_STATUS, 32'h6);
    $display("test move done");
  endtask

  task automatic t_ctrl;
    bw(REG_CTRL, 32'h1);
    dec(1'b0, {CU_SHF, 8'h74, 12'h0}, 1'b1, 1'b1, UNIT_SHF, MUL_NONE, SHF_NONE);
    bw(REG_CTRL, 32'h0);
    dec(1'b0, mf(8'h11), 1'b0, 1'b0, UNIT_MUL, MUL_NONE, SHF_NONE);
    br(REG_CTRL, 32'h0);
    bw(REG_CTRL, 32'h3);
    br(REG_ILL_COUNT, nill);
    br(REG_DEC_COUNT, ndec);
    br(4'h2, 32'h0);
    $display("test control done");
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up;
    end
  end

  initial begin
    mclk = 0; rst = 1; rd = 0; wr = 0; req = 0; req_t6 = 0; req_f = '0; adr = '0; wdat = '0;
    fail_count = 0; comparisons = 0; nill = 0; ndec = 0; cyc = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check({fmsb, flsb}, {6'h26, 6'h09});
    br(REG_CTRL, 32'h3);
    br(REG_ILL_COUNT, 32'h0);
    t_mul;
    t_shf;
    t_move;
    t_ctrl;
    wrap_up;
  end
endmodule // msd_decoder_bench
`default_nettype wire

// File: msd_decoder_checker.sv
/* msd_decoder_checker: port-level relations of the compute decoder.
   Assumes it is bound into msd_decoder; one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module msd_decoder_checker
  import msd_pkg::*;
(
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic       i_avs_read,
  input wire logic       i_avs_write,
  input wire logic       o_avs_waitrequest,
  input wire logic       i_instr_valid,
  input wire logic       i_type6,
  input wire logic [22:0] i_compute,
  input wire logic       o_dec_valid,
  input wire logic       o_illegal,
  input wire msd_unit_t  o_unit,
  input wire msd_mul_op_t o_mul_op,
  input wire logic       o_y_signed,
  input wire logic       o_x_signed,
  input wire logic       o_fractional,
  input wire logic       o_round,
  input wire logic       o_shf_imm,
  input wire logic [7:0] o_imm_data,
  input wire logic       o_move_to_acc,
  input wire logic       o_acc_sel,
  input wire logic [1:0] o_seg_index,
  input wire logic [5:0] o_fld_msb,
  input wire logic [5:0] o_fld_lsb
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_float_in;
    i_instr_valid && !i_type6 && i_compute[22:12] == {CU_MUL, OPC_FLOAT_MUL};
  endsequence
  sequence s_bus_take;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_mul_dec;
    o_dec_valid && o_unit == UNIT_MUL && o_mul_op inside {MUL_PRODUCT, MUL_ACC_ADD, MUL_ACC_SUB};
  endsequence
  property p_fld; o_fld_msb == 6'h26 && o_fld_lsb == 6'h09; endproperty
  property p_sign; s_mul_dec |-> {o_y_signed, o_x_signed} == $past(i_compute[17:16]); endproperty
  property p_frac; s_mul_dec |-> {o_fractional, o_round} == {$past(i_compute[15]), $past(i_compute[12])}; endproperty
  property p_float; s_float_in ##1 o_dec_valid |-> o_unit == UNIT_MUL && o_mul_op == MUL_FLOAT; endproperty
  property p_mdir; o_dec_valid && o_unit == UNIT_MOVE && !o_illegal |-> o_move_to_acc == $past(i_compute[16]); endproperty
  property p_mseg;
    o_dec_valid && o_unit == UNIT_MOVE && !o_illegal |-> {o_acc_sel, o_seg_index} == $past(i_compute[14:12]);
  endproperty
  property p_imm; o_dec_valid && o_shf_imm && !o_illegal |-> o_imm_data == $past(i_compute[15:8]); endproperty
  property p_simm; o_dec_valid |-> o_shf_imm == $past(i_type6); endproperty
  property p_fmt; o_dec_valid && $past(i_type6) && $past(i_compute[22]) |-> o_illegal; endproperty
  // One wait cycle, one acknowledge cycle, then idle again so back-to-back masters cannot double-ack
  property p_ack; s_bus_take |=> !o_avs_waitrequest ##1 o_avs_waitrequest; endproperty
  a_fld: assert property (p_fld) else $error("field bounds wrong");
  a_sign: assert property (p_sign) else $error("operand sign wrong");
  a_frac: assert property (p_frac) else $error("format or round wrong");
  a_float: assert property (p_float) else $error("float multiply missed");
  a_mdir: assert property (p_mdir) else $error("move direction wrong");
  a_mseg: assert property (p_mseg) else $error("move segment wrong");
  a_imm: assert property (p_imm) else $error("immediate data wrong");
  a_simm: assert property (p_simm) else $error("immediate flag wrong");
  a_fmt: assert property (p_fmt) else $error("bad immediate format accepted");
  a_ack: assert property (p_ack) else $error("bus answer timing wrong");
endmodule // msd_decoder_checker
bind msd_decoder msd_decoder_checker u_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .i_instr_valid(i_instr_valid),
  .i_type6(i_type6), .i_compute(i_compute), .o_dec_valid(o_dec_valid), .o_illegal(o_illegal), .o_unit(o_unit),
  .o_mul_op(o_mul_op), .o_y_signed(o_y_signed), .o_x_signed(o_x_signed), .o_fractional(o_fractional),
  .o_round(o_round), .o_shf_imm(o_shf_imm), .o_imm_data(o_imm_data), .o_move_to_acc(o_move_to_acc),
  .o_acc_sel(o_acc_sel), .o_seg_index(o_seg_index), .o_fld_msb(o_fld_msb), .o_fld_lsb(o_fld_lsb));
`default_nettype wire

// File: msd_pkg.sv
/*
 * msd_pkg: constants and types for the multiplier/shifter compute decoder.
 * Assumes nothing of its surroundings; shared by the decoder and its bench.
 */
`default_nettype none
package msd_pkg;
  // Clock
  localparam int unsigned CLK_HZ          = 40_000_000;
  // Register byte offsets
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_STATUS      = 4'h4;
  localparam logic [3:0]  REG_DEC_COUNT   = 4'h8;
  localparam logic [3:0]  REG_ILL_COUNT   = 4'hC;
  // Control fields and reset value
  localparam int unsigned CTRL_DEC_EN_BIT = 0;
  localparam int unsigned CTRL_STREAM_BIT = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h3;
  // Single-function compute field
  localparam int unsigned CU_MSB          = 22;
  localparam int unsigned CU_LSB          = 20;
  localparam int unsigned OPC_MSB         = 19;
  localparam int unsigned OPC_LSB         = 12;
  localparam int unsigned RN_LSB          = 8;
  localparam int unsigned RX_LSB          = 4;
  localparam int unsigned RY_LSB          = 0;
  localparam logic [2:0]  CU_MUL          = 3'h1;
  localparam logic [2:0]  CU_SHF          = 3'h2;
  localparam logic [2:0]  CU_MOVE         = 3'h4;
  // Accumulator move field
  localparam int unsigned MOVE_ZERO_MSB   = 19;
  localparam int unsigned MOVE_ZERO_LSB   = 17;
  localparam int unsigned MOVE_DIR_BIT    = 16;
  localparam int unsigned MOVE_SEG_LSB    = 12;
  localparam int unsigned MOVE_DREG_LSB   = 8;
  localparam int unsigned SEG_BANK_BIT    = 2;
  // Shift-immediate field
  localparam int unsigned IMM_FMT_BIT     = 22;
  localparam int unsigned IMM_OPC_MSB     = 21;
  localparam int unsigned IMM_OPC_LSB     = 16;
  localparam int unsigned IMM_DATA_LSB    = 8;
  localparam int unsigned IMM_RN_LSB      = 4;
  localparam int unsigned IMM_RX_LSB      = 0;
  // Multiply modifier bit positions inside the 8-bit opcode
  localparam int unsigned MOD_Y_BIT       = 5;
  localparam int unsigned MOD_X_BIT       = 4;
  localparam int unsigned MOD_F_BIT       = 3;
  localparam int unsigned MOD_R_BIT       = 0;
  localparam int unsigned DEST_LSB        = 1;
  localparam logic [1:0]  GRP_PRODUCT     = 2'h1;
  localparam logic [1:0]  GRP_ACC_ADD     = 2'h2;
  localparam logic [1:0]  GRP_ACC_SUB     = 2'h3;
  localparam logic [3:0]  HI_CLAMP        = 4'h0;
  localparam logic [3:0]  HI_ROUND        = 4'h1;
  localparam logic [7:0]  OPC_CLR_PRI     = 8'h14;
  localparam logic [7:0]  OPC_CLR_SEC     = 8'h16;
  localparam logic [7:0]  OPC_FLOAT_MUL   = 8'h30;
  // Shifter operand field inside a register-file word
  localparam logic [5:0]  SHF_FLD_MSB     = 6'h26;
  localparam logic [5:0]  SHF_FLD_LSB     = 6'h09;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } msd_bus_state_t;

  typedef enum logic [1:0] {
    UNIT_NONE, UNIT_MUL, UNIT_SHF, UNIT_MOVE
  } msd_unit_t;

  typedef enum logic [2:0] {
    MUL_NONE, MUL_PRODUCT, MUL_ACC_ADD, MUL_ACC_SUB,
    MUL_CLAMP_TO_RANGE, MUL_ROUND_ACCUMULATOR, MUL_CLEAR, MUL_FLOAT
  } msd_mul_op_t;

  typedef enum logic [4:0] {
    SHF_NONE, SHF_LOGICAL, SHF_ARITHMETIC, SHF_CIRCULAR,
    SHF_BIT_SET, SHF_BIT_CLEAR, SHF_BIT_TOGGLE, SHF_BIT_TEST,
    SHF_FIELD_DEPOSIT, SHF_FIELD_EXTRACT, SHF_LEADING_SIGN,
    SHF_LEADING_ZERO, SHF_LEADING_ONE, SHF_PACK, SHF_WIDEN,
    SHF_STREAM_DEPOSIT, SHF_STREAM_EXTRACT, SHF_FIFO_PTR_WRITE, SHF_FIFO_PTR_READ
  } msd_shf_op_t;
endpackage
`default_nettype wire

// File: msd_seq_model.sv
/* msd_seq_model: instruction sequencer issuing one compute field per request.
   Assumes requests arrive synchronous to i_mclk. */
`timescale 1ns/1ps
`default_nettype none
module msd_seq_model (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_req,
  input  wire logic        i_req_type6,
  input  wire logic [22:0] i_req_field,
  output logic             o_instr_valid,
  output logic             o_type6,
  output logic [22:0]      o_compute
);
  // Idle field keeps toggling so a decoder ignoring valid is caught
  always_ff @(posedge i_mclk) begin
    o_instr_valid <= i_req & ~i_rst;
    o_type6       <= i_rst ? 1'b0 : (i_req ? i_req_type6 : ~o_type6);
    o_compute     <= i_rst ? 23'h0 : (i_req ? i_req_field : ~o_compute);
  end
endmodule // msd_seq_model
`default_nettype wire
